/* File: wiper_slave_pkg.sv */
// constants, encodings and state types of the serial wiper slave
// assumes the slave runs on one core clock and samples the bus pins
package wiper_slave_pkg;

    // register map
    localparam logic [7:0] WIPER_ADDR = 8'h00; // wiper position register
    localparam logic [7:0] ACCESS_ADDR = 8'h10; // access control register

    // reset values
    localparam logic [7:0] WIPER_RESET = 8'h80; // mid-scale tap
    localparam logic [7:0] ACCESS_RESET = 8'h42; // fixed bits plus shutdown_n high
    localparam logic SHUTDOWN_N_BIT_N_RESET = 1'b1; // start out of shutdown

    // access control layout
    localparam int SHUTDOWN_N_BIT_N_POS = 6; // shutdown control bit position
    localparam logic [7:0] ACCESS_FIXED = 8'h02; // bits that never change
    localparam logic [7:0] UNMAPPED_READ = 8'h00; // read value of other addresses

    // tap codes
    localparam logic [7:0] TAP_LOW_END = 8'h00; // tap next to the low terminal

    // identification byte layout
    localparam int ID_CODE_MSB = 7; // top of device code field
    localparam int ID_CODE_LSB = 3; // bottom of device code field
    localparam int ID_SEL_HI_POS = 2; // compared with the high select pin
    localparam int ID_SEL_LO_POS = 1; // compared with the low select pin
    localparam int ID_DIR_POS = 0; // 1 read, 0 write

    // bit counting within one byte slot
    localparam logic [3:0] BYTE_BITS = 4'h8; // bits before the ninth clock
    localparam logic [3:0] ACK_CLOCK = 4'h9; // count once the ninth clock rose
    localparam logic [3:0] LAST_TX_FALL = 4'h7; // falls before the line is freed

    // slave sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, // standby, waiting for a start
        ST_RX = 3'b001, // shifting a byte in
        ST_ACK = 3'b010, // pulling the line low on the ninth clock
        ST_TX = 3'b011, // shifting a byte out
        ST_MACK = 3'b100 // sampling the master answer on the ninth clock
    } slave_state_e;

    // which byte of the transfer is being received
    typedef enum logic [1:0] {
        KIND_ID = 2'b00, // identification byte
        KIND_ADDR = 2'b01, // register address byte
        KIND_DATA = 2'b10 // write data byte
    } byte_kind_e;

endpackage : wiper_slave_pkg

/* File: pin_sampler.sv */
// two-stage synchroniser with edge detection for slow pin inputs
// assumes pins are asynchronous to core_clk and idle at RESET_VAL
`timescale 1ns/1ps

module pin_sampler #(
    parameter int WIDTH = 4, // number of pins sampled
    parameter logic [WIDTH-1:0] RESET_VAL = '1 // idle level of the pins
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);

    // refuse an empty sampler
    if (WIDTH < 1) begin : g_width_check
        $error("pin_sampler needs at least one pin");
    end

    // meta is read only by sync; edges compare sync with prev
    typedef struct packed {
        logic [WIDTH-1:0] meta; // first stage
        logic [WIDTH-1:0] sync; // second stage, safe to use
        logic [WIDTH-1:0] prev; // delayed copy for edges
    } sampler_s;

    sampler_s q; // registered state
    sampler_s d; // next state

    // shift the pins down the chain
    always_comb begin
        d = q;
        d.meta = pin_in;
        d.sync = q.meta;
        d.prev = q.sync;
    end

    // reset holds the idle level so no false edge appears
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q <= '{meta: RESET_VAL, sync: RESET_VAL, prev: RESET_VAL};
        end else begin
            q <= d;
        end
    end

    assign level = q.sync;
    assign rise = q.sync & ~q.prev;
    assign fall = ~q.sync & q.prev;

endmodule : pin_sampler

/* File: wiper_slave.sv */
// serial two-wire slave holding the wiper position and access control
// assumes an external master drives the serial clock and pull-ups on both lines
`timescale 1ns/1ps

// Notes on behaviour
// - eight-bit wiper code, 00h low, FFh high
// - wiper code resets to 80h
// - address 0 wiper, address 10h access control
// - access control resets 42h, fixed bits read
// - shutdown bit zero opens ends, wiper low
// - shutdown bit resets to one
// - slave only; master starts and clocks
// - bytes travel most significant bit first
// - data changes only while clock low
// - data line released after reset
// - idle until start; ignore start in reset
// - stop returns the slave to standby
// - ninth clock: receiver pulls data low
// - acknowledge identification, address, write data
// - identification matches code and select pins
// - write updates register on ninth clock
// - read uses repeated start after address
// - sample on rise, shift out after fall
module wiper_slave #(
    parameter logic [4:0] DEVICE_CODE = 5'h0B // arbitrary value, set per product
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic scl_pin, // serial clock from the master
    input wire logic sda_in, // data line level
    output logic sda_out, // data line drive value
    output logic sda_oe, // high while pulling the data line low
    input wire logic addr_select_hi_pin, // upper address select strap
    input wire logic addr_select_lo_pin, // lower address select strap
    output logic [7:0] wiper_position, // stored wiper code
    output logic shutdown_n_bit, // low while in shutdown
    output logic [7:0] tap_select, // tap actually connected
    output logic ends_open // resistor ends disconnected
);

    // overview of the flow:
    //   pins pass the sampler, then edges drive the sequencer
    //   a start always wins over any byte in flight
    //   a stop drops back to standby from any state
    //   registers change only on a synced clock rise
    //   the line is pulled low only, never driven high
    //   one data byte per write, then standby
    //   reads repeat the addressed register

    // whole slave state in one record
    typedef struct packed {
        wiper_slave_pkg::slave_state_e state; // sequencer state
        wiper_slave_pkg::byte_kind_e kind; // byte being received
        logic [3:0] bit_cnt; // clock count in this byte slot
        logic [7:0] shift; // receive or transmit shifter
        logic [7:0] reg_addr; // register address from the master
        logic read_dir; // identification asked for a read
        logic master_ack; // master acknowledged the last byte
        logic [7:0] wiper; // wiper position register
        logic shutdown_n_bit_n; // shutdown control bit
        logic [7:0] tap; // effective tap after shutdown
        logic ends_open; // ends open in shutdown
        logic sda_oe; // open-drain pull enable
    } slave_s;

    // power-up contents
    localparam slave_s RESET_S = '{
        state: wiper_slave_pkg::ST_IDLE,
        kind: wiper_slave_pkg::KIND_ID,
        bit_cnt: 4'h0,
        shift: 8'h00,
        reg_addr: wiper_slave_pkg::WIPER_ADDR,
        read_dir: 1'b0,
        master_ack: 1'b0,
        wiper: wiper_slave_pkg::WIPER_RESET,
        shutdown_n_bit_n: wiper_slave_pkg::SHUTDOWN_N_BIT_N_RESET,
        tap: wiper_slave_pkg::WIPER_RESET,
        ends_open: 1'b0,
        sda_oe: 1'b0
    };

    slave_s q; // registered state
    slave_s d; // next state

    // synchronised pins and their edges
    logic [3:0] pin_level; // scl, sda, select hi, select lo
    logic [3:0] pin_rise; // rising edges
    logic [3:0] pin_fall; // falling edges
    logic scl_lvl; // clock level
    logic sda_lvl; // data level
    logic scl_rise; // clock rose
    logic scl_fall; // clock fell
    logic start_seen; // data fell while clock high
    logic stop_seen; // data rose while clock high

    // pin order in the sampler word:
    //   bit 3 serial clock, bit 2 data line
    //   bit 1 upper select strap, bit 0 lower select strap
    // idle high reset keeps a false start away after reset
    // each pin is two flip-flops away from any logic
    // every pin passes two flip-flops before use
    pin_sampler #(
        .WIDTH(4),
        .RESET_VAL(4'hF)
    ) u_pins (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pin_in({scl_pin, sda_in, addr_select_hi_pin, addr_select_lo_pin}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    assign scl_lvl = pin_level[3];
    assign sda_lvl = pin_level[2];
    assign scl_rise = pin_rise[3];
    assign scl_fall = pin_fall[3];
    // start and stop only count with the clock high
    assign start_seen = pin_fall[2] & scl_lvl;
    assign stop_seen = pin_rise[2] & scl_lvl;

    // identification layout, top bit first:
    //   five device code bits, two strap bits, direction bit
    // straps are compared at the end of the byte, not at the start
    // identification byte check
    function automatic logic id_match(
        input logic [7:0] id_byte,
        input logic sel_hi,
        input logic sel_lo
    );
        logic ok;
        ok = (id_byte[wiper_slave_pkg::ID_CODE_MSB:wiper_slave_pkg::ID_CODE_LSB]
              == DEVICE_CODE);
        ok = ok && (id_byte[wiper_slave_pkg::ID_SEL_HI_POS] == sel_hi);
        ok = ok && (id_byte[wiper_slave_pkg::ID_SEL_LO_POS] == sel_lo);
        return ok;
    endfunction : id_match

    // read data mux shared by first and repeated read bytes
    // unmapped addresses read as zero so a probe sees no junk
    // value returned for a register address
    function automatic logic [7:0] read_value(
        input logic [7:0] addr,
        input logic [7:0] wiper,
        input logic shutdown_n_bit_n
    );
        logic [7:0] v;
        v = wiper_slave_pkg::UNMAPPED_READ;
        if (addr == wiper_slave_pkg::WIPER_ADDR) begin
            v = wiper;
        end else if (addr == wiper_slave_pkg::ACCESS_ADDR) begin
            // fixed bits around the shutdown control
            v = wiper_slave_pkg::ACCESS_FIXED;
            v[wiper_slave_pkg::SHUTDOWN_N_BIT_N_POS] = shutdown_n_bit_n;
        end
        return v;
    endfunction : read_value

    // sequencer outline:
    //   idle -> receive on a start
    //   receive -> acknowledge after eight rises and the next fall
    //   acknowledge -> receive, transmit, or idle after a write data byte, after the ninth fall
    //   transmit -> master answer after the eighth fall
    //   master answer -> transmit on ack, idle on nack
    //   any illegal code falls back to idle
    // bit_cnt counts rises when receiving and falls when sending
    // next-state logic of the byte sequencer
    always_comb begin
        d = q;
        unique case (q.state)
            // standby: only a start moves on, handled below
            wiper_slave_pkg::ST_IDLE: begin
                // bus traffic without a start is ignored here
                d.sda_oe = 1'b0;
            end
            // receive one byte
            wiper_slave_pkg::ST_RX: begin
                if (scl_rise) begin
                    // sample on rise, first bit lands at the top
                    d.shift = {q.shift[6:0], sda_lvl};
                    d.bit_cnt = q.bit_cnt + 4'h1;
                end else if (scl_fall && q.bit_cnt == wiper_slave_pkg::BYTE_BITS) begin
                    // eight bits in: decide on the acknowledge
                    d.bit_cnt = wiper_slave_pkg::BYTE_BITS;
                    unique case (q.kind)
                        wiper_slave_pkg::KIND_ID: begin
                            if (id_match(q.shift, pin_level[1], pin_level[0])) begin
                                d.read_dir = q.shift[wiper_slave_pkg::ID_DIR_POS];
                                d.state = wiper_slave_pkg::ST_ACK;
                                d.sda_oe = 1'b1;
                            end else begin
                                // not addressed: stay off the line
                                d.state = wiper_slave_pkg::ST_IDLE;
                                d.sda_oe = 1'b0;
                            end
                        end
                        wiper_slave_pkg::KIND_ADDR: begin
                            d.reg_addr = q.shift;
                            d.state = wiper_slave_pkg::ST_ACK;
                            d.sda_oe = 1'b1;
                        end
                        wiper_slave_pkg::KIND_DATA: begin
                            d.state = wiper_slave_pkg::ST_ACK;
                            d.sda_oe = 1'b1;
                        end
                        default: begin
                            d.state = wiper_slave_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            // hold the line low through the ninth clock
            wiper_slave_pkg::ST_ACK: begin
                if (scl_rise) begin
                    d.bit_cnt = wiper_slave_pkg::ACK_CLOCK;
                    if (q.kind == wiper_slave_pkg::KIND_DATA) begin
                        // register takes the byte on the ninth clock
                        if (q.reg_addr == wiper_slave_pkg::WIPER_ADDR) begin
                            d.wiper = q.shift;
                        end else if (q.reg_addr == wiper_slave_pkg::ACCESS_ADDR) begin
                            // only the shutdown control is writable
                            d.shutdown_n_bit_n = q.shift[wiper_slave_pkg::SHUTDOWN_N_BIT_N_POS];
                        end
                    end
                end else if (scl_fall && q.bit_cnt == wiper_slave_pkg::ACK_CLOCK) begin
                    // ninth clock over: free the line, pick the next byte
                    d.sda_oe = 1'b0;
                    d.bit_cnt = 4'h0;
                    d.shift = 8'h00;
                    d.state = wiper_slave_pkg::ST_RX;
                    unique case (q.kind)
                        wiper_slave_pkg::KIND_ID: begin
                            if (q.read_dir) begin
                                // first data bit goes out right after the fall
                                d.state = wiper_slave_pkg::ST_TX;
                                d.shift = read_value(q.reg_addr, q.wiper, q.shutdown_n_bit_n);
                                d.sda_oe = ~d.shift[7];
                            end else begin
                                d.kind = wiper_slave_pkg::KIND_ADDR;
                            end
                        end
                        wiper_slave_pkg::KIND_ADDR: begin
                            d.kind = wiper_slave_pkg::KIND_DATA;
                        end
                        wiper_slave_pkg::KIND_DATA: begin
                            // one data byte per write, then standby
                            d.state = wiper_slave_pkg::ST_IDLE;
                        end
                        default: begin
                            d.state = wiper_slave_pkg::ST_IDLE;
                        end
                    endcase
                end
            end
            // shift a byte out, changing only after clock falls
            wiper_slave_pkg::ST_TX: begin
                if (scl_fall) begin
                    if (q.bit_cnt == wiper_slave_pkg::LAST_TX_FALL) begin
                        // eight bits sent: release for the master answer
                        d.sda_oe = 1'b0;
                        d.bit_cnt = 4'h0;
                        d.master_ack = 1'b0;
                        d.state = wiper_slave_pkg::ST_MACK;
                    end else begin
                        d.shift = {q.shift[6:0], 1'b0};
                        d.sda_oe = ~q.shift[6];
                        d.bit_cnt = q.bit_cnt + 4'h1;
                    end
                end
            end
            // ninth clock of a read byte: the master answers
            wiper_slave_pkg::ST_MACK: begin
                // a high line on the ninth rise is a nack
                if (scl_rise) begin
                    d.bit_cnt = wiper_slave_pkg::ACK_CLOCK;
                    if (sda_lvl) begin
                        // nack: last byte, wait for the stop
                        d.state = wiper_slave_pkg::ST_IDLE;
                    end else begin
                        d.master_ack = 1'b1;
                    end
                end else if (scl_fall && q.master_ack) begin
                    // acknowledged: send the register again
                    d.state = wiper_slave_pkg::ST_TX;
                    d.bit_cnt = 4'h0;
                    d.master_ack = 1'b0;
                    d.shift = read_value(q.reg_addr, q.wiper, q.shutdown_n_bit_n);
                    d.sda_oe = ~d.shift[7];
                end
            end
            default: begin
                d.state = wiper_slave_pkg::ST_IDLE;
                d.sda_oe = 1'b0;
            end
        endcase

        // bus conditions override whatever the case above chose;
        // the line is let go so the master can drive the condition
        // a start, also a repeated one, begins a new identification byte
        if (start_seen) begin
            d.state = wiper_slave_pkg::ST_RX;
            d.kind = wiper_slave_pkg::KIND_ID;
            d.bit_cnt = 4'h0;
            d.shift = 8'h00;
            d.master_ack = 1'b0;
            d.sda_oe = 1'b0;
        end else if (stop_seen) begin
            // stop ends any transfer
            d.state = wiper_slave_pkg::ST_IDLE;
            d.bit_cnt = 4'h0;
            d.master_ack = 1'b0;
            d.sda_oe = 1'b0;
        end

        // shutdown opens the ends and parks the wiper low
        d.ends_open = ~d.shutdown_n_bit_n;
        d.tap = d.shutdown_n_bit_n ? d.wiper : wiper_slave_pkg::TAP_LOW_END;
    end

    // every register updates on every core edge;
    // synchronous reset also clears any half-received byte,
    // so a reset mid-frame leaves no stale state
    // state register; starts during reset are never seen
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q <= RESET_S;
        end else begin
            q <= d;
        end
    end

    // all outputs but the constant sda_out come straight from flip-flops, so they
    // never glitch while the sequencer decodes edges
    // open drain: the line is only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe = q.sda_oe;
    assign wiper_position = q.wiper;
    assign shutdown_n_bit = q.shutdown_n_bit_n;
    assign tap_select = q.tap;
    assign ends_open = q.ends_open;

endmodule : wiper_slave

/* File: wiper_slave_props.sv */
// assertions on the wiper slave ports
// assumes serial clock halves of at least six core cycles
`timescale 1ns/1ps
module wiper_slave_props (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic scl_pin,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic addr_select_hi_pin,
    input wire logic addr_select_lo_pin,
    input wire logic [7:0] wiper_position,
    input wire logic shutdown_n_bit,
    input wire logic [7:0] tap_select,
    input wire logic ends_open
);
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // reset frees the line and loads power-up values
    a_reset_state: assert property (
        disable iff (1'b0) sys_rst |=> !sda_oe && shutdown_n_bit && wiper_position == 8'h80)
        else $error("reset state wrong");
    // open drain: only ever pulls low
    a_open_drain: assert property (sda_out == 1'b0)
        else $error("data drive not low");
    // settled shutdown: tap low, ends open
    a_shutdown_n_bit_tap: assert property (
        !shutdown_n_bit && !$past(shutdown_n_bit) |-> tap_select == 8'h00 && ends_open)
        else $error("shutdown tap wrong");
    // settled normal mode: tap follows the wiper code
    a_normal_tap: assert property (
        shutdown_n_bit && $past(shutdown_n_bit) && $stable(wiper_position)
        |-> tap_select == wiper_position && !ends_open)
        else $error("normal tap wrong");
    // line drive moves only while the clock is low
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_pin)
        else $error("drive moved, clock high");
    a_oe_high_hold: assert property ($rose(scl_pin) |=> $stable(sda_oe) [*5])
        else $error("drive moved in high half");
    // a pulled bit stands at least eight core cycles
    a_ack_width: assert property ($rose(sda_oe) |=> sda_oe [*8])
        else $error("pull too short");
    // registers load on a clock high, the ninth rise
    a_reg_on_high: assert property (
        $changed(wiper_position) || $changed(shutdown_n_bit) |-> scl_pin)
        else $error("register moved, clock low");
endmodule : wiper_slave_props

bind wiper_slave wiper_slave_props wiper_slave_props_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .scl_pin(scl_pin), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_select_hi_pin(addr_select_hi_pin), .addr_select_lo_pin(addr_select_lo_pin),
    .wiper_position(wiper_position), .shutdown_n_bit(shutdown_n_bit),
    .tap_select(tap_select), .ends_open(ends_open));

/* File: host.sv */
// behavioural serial bus master for the wiper slave
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ps
module host (
    input wire logic core_clk,
    input wire logic sda_in, // resolved data line
    output logic scl_pin, // clock, high outside frames
    output logic sda_low, // high while pulling data low
    output logic res_valid, // one-cycle result pulse
    output logic [7:0] res_val // ack bit or read byte
);
    localparam int QTR = 3; // core cycles per quarter bit
    initial {scl_pin, sda_low, res_valid, res_val} = {1'b1, 1'b0, 1'b0, 8'h00}; // bus free
    task automatic tick(input int n); // wait core edges
        repeat (n) @(posedge core_clk);
    endtask : tick
    task automatic step(input logic c, input logic d); // set lines, hold a quarter
        scl_pin <= c;
        sda_low <= d;
        tick(QTR);
    endtask : step
    task automatic start_cond(); // master opens frames
        step(scl_pin, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1); // data falls, clock high
        step(1'b0, 1'b1);
    endtask : start_cond
    task automatic stop_cond(); // data rises, clock high
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask : stop_cond
    task automatic clock_bit(input logic b, output logic s); // data moves in low half
        step(1'b0, !b);
        step(1'b1, !b);
        s = sda_in;
        step(1'b1, !b);
        step(1'b0, !b);
    endtask : clock_bit
    task automatic report(input logic [7:0] v); // one result to the bench
        res_val <= v;
        res_valid <= 1'b1;
        tick(1);
        res_valid <= 1'b0;
    endtask : report
    task automatic send_byte(input logic [7:0] b); // msb first, then answer
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
        clock_bit(1'b1, s);
        report({7'h00, s});
    endtask : send_byte
    task automatic recv_byte(input logic last); // ack all but last
        logic [7:0] d;
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(1'b1, d[i]);
        clock_bit(last, s);
        report(d);
    endtask : recv_byte
endmodule : host

/* File: testbench.sv */
// self-checking bench: host model against the wiper slave
// assumes host and the props checker compile first
`timescale 1ns/1ps
module testbench;
    localparam logic [4:0] DEV_CODE = 5'h15; // arbitrary device code
    logic core_clk; // 100 MHz
    logic sys_rst; // synchronous reset
    logic [1:0] sel_q; // select straps
    logic [31:0] rng_q; // xorshift state
    logic [7:0] exp_q [$]; // notes, oldest first
    int num_errors = 0;
    int check_count = 0;
    logic scl_pin, sda_low, res_valid, sda_out, sda_oe, shutdown_n_bit, ends_open;
    logic [7:0] res_val, wiper_position, tap_select;
    wire sda_line = !(sda_low || (sda_oe && !sda_out)); // pulled up unless pulled low
    wiper_slave #(.DEVICE_CODE(DEV_CODE)) wiper_slave_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .scl_pin(scl_pin), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_select_hi_pin(sel_q[1]), .addr_select_lo_pin(sel_q[0]),
        .wiper_position(wiper_position), .shutdown_n_bit(shutdown_n_bit),
        .tap_select(tap_select), .ends_open(ends_open));
    host host_i (.core_clk(core_clk), .sda_in(sda_line), .scl_pin(scl_pin), .sda_low(sda_low),
        .res_valid(res_valid), .res_val(res_val));
    initial begin // core clock
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    always @(posedge core_clk) begin // oldest note against each result
        if (res_valid === 1'b1)
            check(res_val, exp_q.size() ? exp_q.pop_front() : 8'hXX);
    end
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xorshift
    // register write or read; acks noted as 00, read bytes as value
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] v, input int n);
        repeat (3) exp_q.push_back(8'h00);
        repeat (rd ? n : 0) exp_q.push_back(v);
        host_i.start_cond();
        host_i.send_byte({DEV_CODE, sel_q, 1'b0});
        host_i.send_byte(a);
        if (rd) begin
            host_i.start_cond();
            host_i.send_byte({DEV_CODE, sel_q, 1'b1});
            for (int i = 1; i <= n; i++) host_i.recv_byte(i == n);
        end else begin
            host_i.send_byte(v);
        end
        host_i.stop_cond();
    endtask : xfer
    task automatic print_verdict(); // counts, verdict, end
        if (exp_q.size() != 0) num_errors++;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    initial begin // hang limit
        repeat (100000) @(posedge core_clk);
        num_errors++;
        print_verdict();
    end
    initial begin // reset, then the tests
        logic [7:0] v;
        sys_rst = 1'b1;
        sel_q = 2'b00;
        rng_q = 32'h2B205748;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        host_i.tick(4);
        check(wiper_position, 8'h80);
        check({tap_select[7:3], sda_oe, ends_open, shutdown_n_bit}, 8'h81);
        xfer(1'b1, 8'h10, 8'h42, 1);
        xfer(1'b1, 8'h00, 8'h80, 2);
        $display("test reset done");
        for (int k = 0; k < 3; k++) begin // low end, high end, random
            rng_q = xorshift(rng_q);
            v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : rng_q[7:0];
            sel_q <= rng_q[9:8];
            host_i.tick(4);
            xfer(1'b0, 8'h00, v, 1);
            check(tap_select, v);
            xfer(1'b1, 8'h00, v, 1);
        end
        $display("test wiper done");
        xfer(1'b0, 8'h10, 8'hBF, 1);
        check({tap_select[7:2], ends_open, shutdown_n_bit}, 8'h02);
        xfer(1'b1, 8'h10, 8'h02, 1);
        xfer(1'b0, 8'h10, 8'h40, 1);
        check(tap_select, v);
        xfer(1'b0, 8'h05, 8'h33, 1);
        xfer(1'b1, 8'h05, 8'h00, 1);
        check(wiper_position, v);
        $display("test access done");
        for (int k = 0; k < 4; k++) begin // bad straps, then bad code together with bad straps
            repeat (2) exp_q.push_back(8'h01);
            host_i.start_cond();
            host_i.send_byte({DEV_CODE ^ {3'h0, k[1], 1'b0}, sel_q ^ {k[0], !k[0]}, k[1]});
            host_i.send_byte(8'h00);
            host_i.stop_cond();
        end
        $display("test identity done");
        print_verdict();
    end
endmodule : testbench
